// >>> hdl/burst_fifo_map.svh
`ifndef BURST_FIFO_MAP_SVH
`define BURST_FIFO_MAP_SVH

// Data path word width and FIFO depth.
`define WORD_W       18
`define FIFO_DEPTH   64
// Input and output staging registers on each side of the FIFO.
`define STAGE_DEPTH  2
// Largest burst per service grant.
`define BURST_MAX    32
// Polls ignored after the device ends a burst itself.
`define SKIP_POLLS   2'h2
// Room needed to ask for a burst.
`define BURST_ROOM   2

`endif

// >>> hdl/burst_fifo_pkg.sv
package burst_fifo_pkg;

    `include "burst_fifo_map.svh"

    typedef logic [`WORD_W-1:0] word_t;

    // Backplane strobes and levels, already decoded.
    typedef struct packed {
        logic strobe;
        logic data_enable;
        logic poll_strobe;
        logic service_request_poll;
        logic grant;
    } bp_ctrl_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,
        S_POLL  = 2'h1,
        S_BURST = 2'h3,
        S_HOLD  = 2'h2
    } fsm_state_t;

endpackage

// >>> hdl/burst_fifo_transfer_control.sv
`timescale 1ns/10ps
`include "burst_fifo_map.svh"
module burst_fifo_transfer_control
    import burst_fifo_pkg::*;
#(
    parameter int DEPTH     = `FIFO_DEPTH,
    parameter int BURST_MAX = `BURST_MAX
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_device_clear,
    input  wire logic                     i_direction_out,
    input  wire burst_fifo_pkg::bp_ctrl_t i_bp,
    input  wire burst_fifo_pkg::word_t    i_bus_data,
    output burst_fifo_pkg::word_t         o_bus_data,
    output logic                          o_poll_response,
    output logic                          o_burst_request,
    output logic                          o_periph_request,
    input  wire logic                     i_periph_ack,
    input  wire burst_fifo_pkg::word_t    i_periph_data,
    output burst_fifo_pkg::word_t         o_periph_data
);
    import burst_fifo_pkg::*;

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int BW    = $clog2(BURST_MAX + 1);

    if (BURST_MAX < 2 || BURST_MAX > DEPTH)
    begin : g_bad_burst
        $error("BURST_MAX must lie between two and DEPTH");
    end

    bp_ctrl_t         bp;
    bp_ctrl_t         bp_prev;
    logic             ack;
    logic             clear;
    logic             strobe_rise;
    logic             poll_rise;
    logic             ack_rise;
    logic             dir_out;
    fsm_state_t       state;
    fsm_state_t       next_state;
    logic [1:0]       skip;
    logic [BW-1:0]    beats;
    logic             req_seen;
    word_t            in_stage [`STAGE_DEPTH];
    word_t            out_stage [`STAGE_DEPTH];
    logic [1:0]       in_cnt;
    logic [1:0]       out_cnt;
    logic             in_push;
    logic             in_pop;
    logic             out_load;
    logic             out_pop;
    logic             fifo_in_valid;
    logic             fifo_in_ready;
    word_t            fifo_in_data;
    logic             fifo_out_valid;
    logic             fifo_out_ready;
    word_t            fifo_out_data;
    logic [CNT_W-1:0] fifo_count;
    logic [CNT_W:0]   free_words;
    logic             ready_answer;
    logic             burst_ok;
    logic             periph_req;
    logic             periph_busy;
    logic             periph_push;
    logic             periph_pop;

    sync_stage #(
        .WIDTH ($bits(bp_ctrl_t) + 2)
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_bp, i_periph_ack, i_device_clear}),
        .o_sync    ({bp, ack, clear})
    );

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bp_prev <= '0;
        end
        else
        begin
            bp_prev <= bp;
        end
    end

    assign strobe_rise = bp.strobe && !bp_prev.strobe && bp.data_enable;
    assign poll_rise   = bp.poll_strobe && !bp_prev.poll_strobe;

    // Direction is taken only while the path is cleared.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            dir_out <= 1'b0;
        end
        else if (clear)
        begin
            dir_out <= i_direction_out;
        end
    end

    word_fifo #(
        .WIDTH ($bits(word_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_clear     (clear),
        .i_in_valid  (fifo_in_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data),
        .o_count     (fifo_count)
    );

    assign fifo_in_valid  = dir_out ? periph_push : in_pop;
    assign fifo_in_data   = dir_out ? i_periph_data : in_stage[0];
    assign fifo_out_ready = dir_out ? out_load : periph_pop;
    assign free_words     = (CNT_W + 1)'(DEPTH) - {1'b0, fifo_count};

    // Input staging: words from the bus, including late ones after a drop.
    assign in_push = strobe_rise && !dir_out && (in_cnt != 2'h2);
    assign in_pop  = !dir_out && (in_cnt != 2'h0) && fifo_in_ready
                     && (state != S_HOLD || poll_rise);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            in_cnt   <= 2'h0;
            in_stage <= '{default: '0};
        end
        else if (clear)
        begin
            in_cnt <= 2'h0;
        end
        else
        begin
            unique case ({in_push, in_pop})
                2'b10:
                begin
                    in_stage[in_cnt[0]] <= i_bus_data;
                    in_cnt              <= in_cnt + 2'h1;
                end
                2'b01:
                begin
                    in_stage[0] <= in_stage[1];
                    in_cnt      <= in_cnt - 2'h1;
                end
                2'b11:
                begin
                    in_stage[0]         <= (in_cnt == 2'h1) ? i_bus_data : in_stage[1];
                    in_stage[in_cnt[0]] <= i_bus_data;
                end
                2'b00:
                begin
                end
            endcase
        end
    end

    // Output staging: loaded on poll edges, or freely during a burst.
    assign out_load = dir_out && fifo_out_valid && (out_cnt != 2'h2)
                      && (state == S_BURST || poll_rise);
    assign out_pop  = strobe_rise && dir_out && (out_cnt != 2'h0);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            out_cnt   <= 2'h0;
            out_stage <= '{default: '0};
        end
        else if (clear)
        begin
            out_cnt <= 2'h0;
        end
        else
        begin
            unique case ({out_load, out_pop})
                2'b10:
                begin
                    out_stage[out_cnt[0]] <= fifo_out_data;
                    out_cnt               <= out_cnt + 2'h1;
                end
                2'b01:
                begin
                    out_stage[0] <= out_stage[1];
                    out_cnt      <= out_cnt - 2'h1;
                end
                2'b11:
                begin
                    out_stage[0] <= (out_cnt == 2'h1) ? fifo_out_data : out_stage[1];
                    out_stage[1] <= fifo_out_data;
                end
                2'b00:
                begin
                end
            endcase
        end
    end

    assign o_bus_data = out_stage[0];

    // Answer polls with one word of room or data; no held inbound words.
    assign ready_answer = dir_out ? (out_cnt != 2'h0)
                                  : (fifo_in_ready && in_cnt == 2'h0);
    // Burst needs two words of room, or more than one word on hand.
    assign burst_ok = dir_out ? (out_cnt == 2'h2 || (out_cnt != 2'h0 && fifo_count != '0))
                              : (free_words >= (CNT_W + 1)'(in_cnt) + (CNT_W + 1)'(`BURST_ROOM));

    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:
            begin
                if (ready_answer && skip == 2'h0)
                begin
                    next_state = S_POLL;
                end
            end
            S_POLL:
            begin
                if (bp.grant)
                begin
                    next_state = S_BURST;
                end
                else if (!ready_answer)
                begin
                    next_state = S_IDLE;
                end
            end
            S_BURST:
            begin
                if (!bp.grant)
                begin
                    next_state = S_IDLE;
                end
                else if (req_seen && !burst_ok && beats < BW'(BURST_MAX))
                begin
                    next_state = S_HOLD;
                end
            end
            S_HOLD:
            begin
                if (skip == 2'h0 && in_cnt == 2'h0)
                begin
                    next_state = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= S_IDLE;
        end
        else if (clear)
        begin
            state <= S_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Poll-skip count: loaded when the device ends a burst itself.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            skip <= 2'h0;
        end
        else if (clear)
        begin
            skip <= 2'h0;
        end
        else if (state == S_BURST && next_state == S_HOLD)
        begin
            skip <= `SKIP_POLLS;
        end
        else if (poll_rise && skip != 2'h0)
        begin
            skip <= skip - 2'h1;
        end
    end

    // Words per grant, and whether the request was raised in this grant.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            beats    <= '0;
            req_seen <= 1'b0;
        end
        else if (clear || state != S_BURST)
        begin
            beats    <= '0;
            req_seen <= 1'b0;
        end
        else
        begin
            if (strobe_rise && beats != BW'(BURST_MAX))
            begin
                beats <= beats + BW'(1);
            end
            if (o_burst_request)
            begin
                req_seen <= 1'b1;
            end
        end
    end

    assign o_poll_response = (state == S_POLL) && ready_answer && bp.service_request_poll;
    assign o_burst_request = (state == S_BURST) && bp.grant && burst_ok
                             && (beats < BW'(BURST_MAX));

    // Peripheral handshake, run only from FIFO room or data.
    assign ack_rise    = ack && !periph_busy;
    assign periph_push = periph_req && ack_rise && dir_out;
    assign periph_pop  = periph_req && ack_rise && !dir_out;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            periph_req  <= 1'b0;
            periph_busy <= 1'b0;
        end
        else if (clear)
        begin
            periph_req  <= 1'b0;
            periph_busy <= 1'b0;
        end
        else if (periph_req && ack)
        begin
            periph_req  <= 1'b0;
            periph_busy <= 1'b1;
        end
        else if (periph_busy && !ack)
        begin
            periph_busy <= 1'b0;
        end
        else if (!periph_busy && !periph_req && (dir_out ? fifo_in_ready : fifo_out_valid))
        begin
            periph_req <= 1'b1;
        end
    end

    assign o_periph_request = periph_req;
    assign o_periph_data    = fifo_out_data;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_offer;
        o_periph_request && !dir_out && !ack;
    endsequence

    sequence s_self_drop;
        state == S_BURST && bp.grant && req_seen && !burst_ok && beats < BW'(BURST_MAX) && !clear;
    endsequence

    a_offer_held : assert property (s_offer |=> $stable(o_periph_data) && (o_periph_request || ack))
        else $error("Offered peripheral word changed before acceptance");
    a_skip_two_polls : assert property (s_self_drop |=> state == S_HOLD && skip == 2'h2)
        else $error("Self-ended burst did not load two skipped polls");
    a_hold_no_answer : assert property ((state == S_HOLD) |-> !o_poll_response)
        else $error("Poll answered while skipping");
    a_held_no_answer : assert property ((in_cnt != 2'h0 && !dir_out) |-> !o_poll_response)
        else $error("Poll answered while inbound words are held");
    a_in_room_poll : assert property ((o_poll_response && !dir_out) |-> fifo_in_ready)
        else $error("Inbound poll answered without room");
    a_out_data_poll : assert property ((o_poll_response && dir_out) |-> out_cnt != 2'h0)
        else $error("Outbound poll answered with no staged word");
    a_burst_room : assert property ((o_burst_request && !dir_out)
                                    |-> free_words >= (CNT_W + 1)'(in_cnt) + (CNT_W + 1)'(2))
        else $error("Inbound burst requested with room under two words");
    a_single_word : assert property ((dir_out && out_cnt == 2'h1 && fifo_count == '0) |-> !o_burst_request)
        else $error("Burst requested with a single outbound word");
    a_clear_idle : assert property (clear |=> state == S_IDLE && skip == 2'h0 && in_cnt == 2'h0
                                    && out_cnt == 2'h0 && !o_burst_request)
        else $error("Clear left the data path or machine busy");
    a_strobe_gate : assert property ((bp.strobe && !bp_prev.strobe && !bp.data_enable)
                                     |-> !in_push && !out_pop)
        else $error("Bus strobe moved data without the enable");
endmodule

// >>> hdl/sync_stage.sv
`timescale 1ns/10ps
module sync_stage #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("sync_stage needs WIDTH of at least one");
    end

    // Two flip-flops per bit; only the second one is seen outside.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta   <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// >>> hdl/word_fifo.sv
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 64,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_clear,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic      [CNT_W-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CNT_W-1:0] mem_cnt;
    logic             push;
    logic             take;
    logic             load;

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("word_fifo DEPTH must be a power of two, at least four");
    end

    assign o_count    = mem_cnt + CNT_W'(o_out_valid);
    assign o_in_ready = o_count < CNT_W'(DEPTH);
    assign push       = i_in_valid && o_in_ready;
    assign take       = o_out_valid && i_out_ready;
    assign load       = (mem_cnt != '0) && (!o_out_valid || take);

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Head word is held in a register so read data never come from the array.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            mem_cnt     <= '0;
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end
        else if (i_clear)
        begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            mem_cnt     <= '0;
            o_out_valid <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (load)
            begin
                rd_ptr     <= rd_ptr + AW'(1);
                o_out_data <= mem[rd_ptr];
            end
            mem_cnt <= mem_cnt + CNT_W'(push) - CNT_W'(load);
            if (load)
            begin
                o_out_valid <= 1'b1;
            end
            else if (take)
            begin
                o_out_valid <= 1'b0;
            end
        end
    end

    a_fifo_full_stop : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_count == CNT_W'(DEPTH)) |-> !o_in_ready)
        else $error("FIFO offers room while holding DEPTH words");

    a_fifo_count_step : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (push && !take && !i_clear) |=> (o_count == $past(o_count) + CNT_W'(1)))
        else $error("FIFO count did not rise by one on a write");
endmodule

// >>> tb/periph_model.sv
`timescale 1ns/10ps
module periph_model
    import burst_fifo_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_reset_n,
    input  wire logic  i_dir_out,
    input  wire logic  i_request,
    input  wire word_t i_data,
    output logic       o_ack,
    output word_t      o_data
);
    int unsigned sent;
    int unsigned wait_n;
    word_t       rx_q[$];
    // Set by the bench to stall the handshake.
    bit          hold_off;

    // Answers each request once seen, after a random stall, and holds the word until the request drops.
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ack  <= 1'b0;
            o_data <= '0;
            sent   = 0;
            wait_n = 0;
        end
        else if (o_ack)
        begin
            if (!i_request)
            begin
                o_ack  <= 1'b0;
                o_data <= ~o_data;
            end
        end
        else if (i_request && !hold_off)
        begin
            if (wait_n != 0)
            begin
                wait_n = wait_n - 1;
            end
            else
            begin
                o_ack <= 1'b1;
                if (i_dir_out)
                begin
                    o_data <= word_t'(sent * 18'h00137 + 18'h00005);
                    sent   = sent + 1;
                end
                else
                begin
                    rx_q.push_back(i_data);
                end
                wait_n = $urandom_range(0, 3);
            end
        end
    end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import burst_fifo_pkg::*;

    logic        i_clk;
    logic        i_reset_n;
    logic        i_device_clear;
    logic        i_direction_out;
    bp_ctrl_t    i_bp;
    word_t       i_bus_data;
    word_t       o_bus_data;
    logic        o_poll_response;
    logic        o_burst_request;
    logic        o_periph_request;
    logic        i_periph_ack;
    word_t       i_periph_data;
    word_t       o_periph_data;
    int          n_fail;
    int          check_count;
    int unsigned k;
    int unsigned base;
    word_t       sent_q[$];

    burst_fifo_transfer_control #(.DEPTH(64), .BURST_MAX(32)) dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_device_clear(i_device_clear),
        .i_direction_out(i_direction_out), .i_bp(i_bp), .i_bus_data(i_bus_data),
        .o_bus_data(o_bus_data), .o_poll_response(o_poll_response),
        .o_burst_request(o_burst_request), .o_periph_request(o_periph_request),
        .i_periph_ack(i_periph_ack), .i_periph_data(i_periph_data), .o_periph_data(o_periph_data));

    periph_model pm (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_dir_out(i_direction_out),
        .i_request(o_periph_request), .i_data(o_periph_data), .o_ack(i_periph_ack), .o_data(i_periph_data));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic word_t exp_word(input int unsigned i);
        return word_t'(i * 18'h00137 + 18'h00005);
    endfunction

    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wait_rx(input int n);
        int unsigned t;
        for (t = 0; t < 3000 && pm.rx_q.size() < n; t++)
            cyc(1);
        if (t == 3000)
        begin
            n_fail++;
            close_out();
        end
    endtask

    task automatic pulse_poll();
        @(posedge i_clk);
        i_bp.poll_strobe <= 1'b1;
        cyc(3);
        i_bp.poll_strobe <= 1'b0;
        cyc(3);
    endtask

    task automatic bus_beat(input logic en, input word_t d);
        @(posedge i_clk);
        i_bus_data       <= d;
        i_bp.data_enable <= en;
        i_bp.strobe      <= 1'b1;
        cyc(3);
        i_bp.strobe <= 1'b0;
        cyc(3);
    endtask

    task automatic clear_path(input logic dir);
        @(posedge i_clk);
        i_device_clear  <= 1'b1;
        i_direction_out <= dir;
        cyc(4);
        i_device_clear <= 1'b0;
        cyc(4);
    endtask

    task automatic open_service();
        @(posedge i_clk);
        i_bp.service_request_poll <= 1'b1;
        cyc(4);
        check("poll_response", o_poll_response, 1);
        i_bp.grant <= 1'b1;
        cyc(4);
        i_bp.service_request_poll <= 1'b0;
        cyc(1);
    endtask

    task automatic close_service();
        @(posedge i_clk);
        i_bp.grant <= 1'b0;
        cyc(4);
    endtask

    initial
    begin
        i_reset_n       = 1'b0;
        i_device_clear  = 1'b0;
        i_direction_out = 1'b0;
        i_bp            = '0;
        i_bus_data      = '0;
        n_fail          = 0;
        check_count     = 0;
        k = $urandom(32'hE51133F7);
        cyc(10);
        i_reset_n <= 1'b1;
        cyc(2);
        check("burst_request", o_burst_request, 0);
        check("periph_request", o_periph_request, 0);
        // Outbound: the peripheral fills the path, then the backplane drains a full burst.
        clear_path(1'b1);
        cyc(1200);
        check("words_taken", pm.sent, 64);
        check("periph_request", o_periph_request, 0);
        pulse_poll();
        pulse_poll();
        check("first_staged", o_bus_data, exp_word(0));
        bus_beat(1'b0, 18'h3FFFF);
        check("strobe_disabled", o_bus_data, exp_word(0));
        open_service();
        check("burst_request", o_burst_request, 1);
        for (int i = 0; i < 32; i++)
        begin
            check("bus_data", o_bus_data, exp_word(i));
            bus_beat(1'b1, 18'h00000);
        end
        check("burst_limit", o_burst_request, 0);
        close_service();
        // Inbound after a clear: random words go to the stalling peripheral in order.
        clear_path(1'b0);
        check("poll_idle", o_poll_response, 0);
        check("burst_idle", o_burst_request, 0);
        open_service();
        check("burst_request", o_burst_request, 1);
        for (int i = 0; i < 10; i++)
        begin
            sent_q.push_back(word_t'($urandom_range(0, 18'h3FFFF)));
            bus_beat(1'b1, sent_q[i]);
        end
        close_service();
        wait_rx(10);
        for (int i = 0; i < 10; i++)
            check("periph_word", pm.rx_q[i], sent_q[i]);
        // Inbound fill with a stalled peripheral: the burst drops, the late word is held, two polls are skipped.
        pm.hold_off <= 1'b1;
        clear_path(1'b0);
        for (int g = 0; g < 2; g++)
        begin
            open_service();
            for (int i = 0; i < 32; i++)
            begin
                check("fill_burst", o_burst_request, (g == 0 || i < 31));
                sent_q.push_back(word_t'($urandom_range(0, 18'h3FFFF)));
                bus_beat(1'b1, sent_q[10 + 32 * g + i]);
            end
            close_service();
        end
        i_bp.service_request_poll <= 1'b1;
        pulse_poll();
        check("poll_skipped", o_poll_response, 0);
        pulse_poll();
        i_bp.service_request_poll <= 1'b0;
        pm.hold_off <= 1'b0;
        wait_rx(74);
        for (int i = 10; i < 74; i++)
            check("fill_word", pm.rx_q[i], sent_q[i]);
        // Outbound with a single word on hand: it is sent without a burst request.
        pm.hold_off <= 1'b1;
        clear_path(1'b1);
        base = pm.sent;
        pm.hold_off <= 1'b0;
        for (k = 0; k < 200 && pm.sent == base; k++)
            cyc(1);
        pm.hold_off <= 1'b1;
        if (k == 200)
        begin
            n_fail++;
            close_out();
        end
        cyc(8);
        pulse_poll();
        open_service();
        check("single_burst", o_burst_request, 0);
        check("single_word", o_bus_data, exp_word(base));
        bus_beat(1'b1, 18'h00000);
        close_service();
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        cyc(2);
        check("reset_request", o_periph_request, 0);
        check("reset_burst", o_burst_request, 0);
        close_out();
    end
endmodule
